// ==== rtl/hdb_top.sv ====
// hub descriptor builder: apb slave plus byte streamer
`timescale 1ns/1ps
`default_nettype none
module hdb_top #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// descriptor byte stream
	output logic [7:0] desc_byte,
	output logic desc_valid,
	output logic desc_last,
	output logic desc_busy
);
	import hdb_pkg::*;

	// five address bits reach every register; the decode itself is twelve wide
	if (ADDR_W < 5 || ADDR_W > 12) begin
		$error("hdb_top: ADDR_W must be 5..12");
	end

	function automatic logic [31:0] apply_strb(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		apply_strb = r;
	endfunction

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_DONE = 2'b10
	} hdb_state_t;

	typedef enum logic [2:0] {
		RG_CTRL = 3'b000,
		RG_CFG0 = 3'b001,
		RG_CFG1 = 3'b010,
		RG_STATUS = 3'b011,
		RG_DATA = 3'b100,
		RG_NONE = 3'b111
	} hdb_reg_t;

	// one decode shared by the write side, the read side and the error answer
	function automatic hdb_reg_t reg_decode(input logic [11:0] a);
		hdb_reg_t r;
		if (a == REG_CTRL) begin
			r = RG_CTRL;
		end else if (a == REG_CFG0) begin
			r = RG_CFG0;
		end else if (a == REG_CFG1) begin
			r = RG_CFG1;
		end else if (a == REG_STATUS) begin
			r = RG_STATUS;
		end else if (a == REG_DATA) begin
			r = RG_DATA;
		end else begin
			r = RG_NONE;
		end
		return r;
	endfunction

	logic [31:0] cfg0_ff;
	logic [31:0] cfg1_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [7:0] desc_byte_ff;
	logic desc_valid_ff;
	logic desc_last_ff;
	logic desc_busy_ff;
	hdb_state_t state_ff;
	hdb_state_t nxt_state;
	hdb_sel_t sel_ff;
	logic [3:0] idx_ff;
	logic [7:0] remain_ff;
	logic err_ff;
	logic [7:0] req_type_ff;
	logic [7:0] req_len_ff;

	logic [11:0] addr12;
	logic access;
	logic cfg_wr;
	hdb_reg_t reg_sel;
	logic wr_ok;
	logic rd_ok;
	logic addr_hit;
	logic start;
	hdb_sel_t req_sel;
	logic [7:0] rom_data;
	logic [7:0] rom_len;
	logic [7:0] first_len;

	assign addr12 = 12'(paddr);
	assign access = psel && penable && !pready_ff;
	assign reg_sel = reg_decode(addr12);
	assign addr_hit = (reg_sel != RG_NONE);
	assign wr_ok = access && pwrite && addr_hit;
	assign rd_ok = access && !pwrite && addr_hit;
	// configuration and control only change between streams
	assign cfg_wr = wr_ok && (state_ff == ST_IDLE);
	// a write to the control word launches a descriptor fetch
	assign start = cfg_wr && (reg_sel == RG_CTRL);

	always_comb begin
		if (pwdata[7:0] == USB_DT_INTERFACE) begin
			req_sel = SEL_IF;
		end else if (pwdata[7:0] == USB_DT_ENDPOINT) begin
			req_sel = SEL_EP;
		end else if (pwdata[7:0] == HUB_TYPE || pwdata[7:0] == HUB_TYPE_LEGACY) begin
			req_sel = SEL_HUB;
		end else begin
			req_sel = SEL_NONE;
		end
	end

	hdb_rom u_rom (
		.sel(sel_ff),
		.index(idx_ff),
		.power_source_select(cfg0_ff[CFG0_PSRC]),
		.bus_powered_port_disable_mask(cfg0_ff[CFG0_BPDIS +: 3]),
		.self_powered_port_disable_mask(cfg0_ff[CFG0_SPDIS +: 3]),
		.port_power_switching_mode(cfg0_ff[CFG0_PPSW]),
		.compound_flag(cfg0_ff[CFG0_COMP]),
		.overcurrent_sense_mode(cfg0_ff[CFG0_OCS +: 2]),
		.power_on_time(cfg0_ff[CFG0_PONT +: 8]),
		.hub_ctrl_current_bp(cfg1_ff[7:0]),
		.hub_ctrl_current_sp(cfg1_ff[15:8]),
		.nonremovable_mask(cfg0_ff[CFG0_NRDEV +: 8]),
		.data(rom_data),
		.length(rom_len)
	);

	// bytes to send: the smaller of requested and descriptor length
	assign first_len = (req_len_ff < rom_len) ? req_len_ff : rom_len;

	// configuration words; loaded only while idle, so a stream sees one snapshot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg0_ff <= CFG0_RST;
		end else if (cfg_wr && reg_sel == RG_CFG0) begin
			cfg0_ff <= apply_strb(cfg0_ff, pwdata, pstrb);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg1_ff <= CFG1_RST;
		end else if (cfg_wr && reg_sel == RG_CFG1) begin
			cfg1_ff <= apply_strb(cfg1_ff, pwdata, pstrb);
		end
	end

	// apb answer: one wait state, pready in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
		end else begin
			pready_ff <= access;
		end
	end

	// unmapped offsets answer with an error and have no other effect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_ff <= 1'b0;
		end else begin
			pslverr_ff <= access && !addr_hit;
		end
	end

	// read data stands with pready only; zero otherwise so stale words never leak
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= CTRL_RST;
		end else if (!rd_ok) begin
			prdata_ff <= 32'h0000_0000;
		end else if (reg_sel == RG_CTRL) begin
			prdata_ff <= {16'h0000, req_len_ff, req_type_ff};
		end else if (reg_sel == RG_CFG0) begin
			prdata_ff <= cfg0_ff;
		end else if (reg_sel == RG_CFG1) begin
			prdata_ff <= cfg1_ff;
		end else if (reg_sel == RG_STATUS) begin
			prdata_ff <= {28'h0, err_ff, desc_busy_ff, state_ff};
		end else begin
			prdata_ff <= {24'h0, desc_byte_ff};
		end
	end

	// request capture: taken once per accepted control write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_type_ff <= 8'h00;
		end else if (start) begin
			req_type_ff <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_len_ff <= 8'h00;
		end else if (start) begin
			req_len_ff <= pwdata[15:8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_ff <= SEL_NONE;
		end else if (start) begin
			sel_ff <= req_sel;
		end
	end

	// unknown type or zero length: nothing is sent, the error bit tells software why
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_ff <= 1'b0;
		end else if (start) begin
			err_ff <= (req_sel == SEL_NONE) || (pwdata[15:8] == 8'h00);
		end
	end

	// streamer state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start) begin
					nxt_state = ST_DONE;
					if (req_sel != SEL_NONE && pwdata[15:8] != 8'h00) begin
						nxt_state = ST_SEND;
					end
				end
			end
			ST_SEND: begin
				if (remain_ff == 8'd1 || (idx_ff == 4'd0 && first_len == 8'd1)) begin
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// byte index, ascending offsets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_ff <= 4'd0;
		end else if (state_ff == ST_SEND) begin
			idx_ff <= idx_ff + 4'd1;
		end else begin
			idx_ff <= 4'd0;
		end
	end

	// bytes still owed; loaded from first_len on the first byte, truncating the reply
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remain_ff <= 8'd0;
		end else if (state_ff == ST_SEND) begin
			remain_ff <= ((idx_ff == 4'd0) ? first_len : remain_ff) - 8'd1;
		end else begin
			remain_ff <= 8'd0;
		end
	end

	// output stream registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			desc_valid_ff <= 1'b0;
		end else begin
			desc_valid_ff <= (state_ff == ST_SEND);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			desc_last_ff <= 1'b0;
		end else begin
			desc_last_ff <= (state_ff == ST_SEND) && (nxt_state == ST_DONE);
		end
	end

	// busy covers the cycle before the first byte and the last byte itself
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			desc_busy_ff <= 1'b0;
		end else begin
			desc_busy_ff <= (nxt_state == ST_SEND) || (state_ff == ST_SEND);
		end
	end

	// the byte register keeps the last byte sent, which the data register reads back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			desc_byte_ff <= 8'h00;
		end else if (state_ff == ST_SEND) begin
			desc_byte_ff <= rom_data;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign desc_byte = desc_byte_ff;
	assign desc_valid = desc_valid_ff;
	assign desc_last = desc_last_ff;
	assign desc_busy = desc_busy_ff;
endmodule
`default_nettype wire

// ==== rtl/hdb_pkg.sv ====
// package of constants for the hub descriptor builder
package hdb_pkg;
	localparam logic [7:0] IF_LEN = 8'h09;
	localparam logic [7:0] IF_TYPE = 8'h04;
	localparam logic [7:0] IF_NUM = 8'h00;
	localparam logic [7:0] IF_ALT = 8'h00;
	localparam logic [7:0] IF_NUM_EP = 8'h01;
	localparam logic [7:0] IF_CLASS_HUB = 8'h09;
	localparam logic [7:0] IF_SUBCLASS = 8'h00;
	localparam logic [7:0] IF_PROTOCOL = 8'h00;
	localparam logic [7:0] IF_STRING = 8'h00;
	localparam logic [7:0] EP_LEN = 8'h07;
	localparam logic [7:0] EP_TYPE = 8'h05;
	localparam logic [7:0] EP_ADDR = 8'h81;
	localparam logic [7:0] EP_ATTR = 8'h03;
	localparam logic [15:0] EP_MAXPKT = 16'h0001;
	localparam logic [7:0] EP_INTERVAL = 8'hff;
	localparam logic [7:0] HUB_LEN = 8'h09;
	localparam logic [7:0] HUB_TYPE = 8'h29;
	localparam logic [7:0] HUB_TYPE_LEGACY = 8'h00;
	localparam logic [7:0] HUB_PWR_CTRL_MASK = 8'hff;
	localparam logic [1:0] TOTAL_PORTS = 2'd3;
	localparam logic [7:0] USB_DT_INTERFACE = 8'h04;
	localparam logic [7:0] USB_DT_ENDPOINT = 8'h05;
	// apb register map (32-bit words)
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_CFG0 = 12'h004;
	localparam logic [11:0] REG_CFG1 = 12'h008;
	localparam logic [11:0] REG_STATUS = 12'h00c;
	localparam logic [11:0] REG_DATA = 12'h010;
	// field positions in REG_CFG0
	localparam int CFG0_PSRC = 0;
	localparam int CFG0_PPSW = 1;
	localparam int CFG0_COMP = 2;
	localparam int CFG0_OCS = 3;
	localparam int CFG0_BPDIS = 8;
	localparam int CFG0_SPDIS = 12;
	localparam int CFG0_PONT = 16;
	localparam int CFG0_NRDEV = 24;
	// reset (internal default) values
	localparam logic [31:0] CFG0_RST = 32'h3200_0008;
	localparam logic [31:0] CFG1_RST = 32'h0000_0032;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	typedef enum logic [1:0] {
		SEL_IF = 2'b00,
		SEL_EP = 2'b01,
		SEL_HUB = 2'b10,
		SEL_NONE = 2'b11
	} hdb_sel_t;
endpackage

// ==== rtl/hdb_rom.sv ====
// byte lookup for the three descriptors
`timescale 1ns/1ps
`default_nettype none
module hdb_rom (
	// selection
	input wire hdb_pkg::hdb_sel_t sel,
	input wire logic [3:0] index,
	// configuration
	input wire logic power_source_select,
	input wire logic [2:0] bus_powered_port_disable_mask,
	input wire logic [2:0] self_powered_port_disable_mask,
	input wire logic port_power_switching_mode,
	input wire logic compound_flag,
	input wire logic [1:0] overcurrent_sense_mode,
	input wire logic [7:0] power_on_time,
	input wire logic [7:0] hub_ctrl_current_bp,
	input wire logic [7:0] hub_ctrl_current_sp,
	input wire logic [7:0] nonremovable_mask,
	// result
	output logic [7:0] data,
	output logic [7:0] length
);
	import hdb_pkg::*;

	function automatic logic [1:0] popcount3(input logic [2:0] m);
		popcount3 = {1'b0, m[0]} + {1'b0, m[1]} + {1'b0, m[2]};
	endfunction

	logic [2:0] dis_mask;
	logic [7:0] nbr_ports;
	logic [15:0] hub_char;

	always_comb begin
		dis_mask = power_source_select ? self_powered_port_disable_mask
			: bus_powered_port_disable_mask;
		nbr_ports = {6'd0, TOTAL_PORTS - popcount3(dis_mask)};
		hub_char = 16'h0000;
		// a zero setting reports ganged switching, a one reports '01'; the '1x' codes are not taken
		hub_char[1:0] = port_power_switching_mode ? 2'b01 : 2'b00;
		hub_char[2] = compound_flag;
		hub_char[4:3] = overcurrent_sense_mode;
	end

	always_comb begin
		data = 8'h00;
		length = 8'h00;
		case (sel)
			SEL_IF: begin
				length = IF_LEN;
				case (index)
					4'd0: data = IF_LEN;
					4'd1: data = IF_TYPE;
					4'd2: data = IF_NUM;
					4'd3: data = IF_ALT;
					4'd4: data = IF_NUM_EP;
					4'd5: data = IF_CLASS_HUB;
					4'd6: data = IF_SUBCLASS;
					4'd7: data = IF_PROTOCOL;
					4'd8: data = IF_STRING;
					default: data = 8'h00;
				endcase
			end
			SEL_EP: begin
				length = EP_LEN;
				case (index)
					4'd0: data = EP_LEN;
					4'd1: data = EP_TYPE;
					4'd2: data = EP_ADDR;
					4'd3: data = EP_ATTR;
					4'd4: data = EP_MAXPKT[7:0];
					4'd5: data = EP_MAXPKT[15:8];
					4'd6: data = EP_INTERVAL;
					default: data = 8'h00;
				endcase
			end
			SEL_HUB: begin
				length = HUB_LEN;
				case (index)
					4'd0: data = HUB_LEN;
					4'd1: data = HUB_TYPE;
					4'd2: data = nbr_ports;
					4'd3: data = hub_char[7:0];
					4'd4: data = hub_char[15:8];
					4'd5: data = power_on_time;
					4'd6: data = power_source_select ? hub_ctrl_current_sp
						: hub_ctrl_current_bp;
					4'd7: data = nonremovable_mask;
					4'd8: data = HUB_PWR_CTRL_MASK;
					default: data = 8'h00;
				endcase
			end
			default: begin
				data = 8'h00;
				length = 8'h00;
			end
		endcase
	end
endmodule
`default_nettype wire

// ==== verif/hdb_chk_assertions.sv ====
// assertions on the ports of the hub descriptor builder
`timescale 1ns/1ps
`default_nettype none
module hdb_chk #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// stream
	input wire logic [7:0] desc_byte,
	input wire logic desc_valid,
	input wire logic desc_last,
	input wire logic desc_busy
);
	import hdb_pkg::*;
	// byte index and descriptor kind, taken from the second byte
	logic [3:0] cnt_ff;
	logic [7:0] kind_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cnt_ff <= 4'h0;
		else if (desc_valid) cnt_ff <= desc_last ? 4'h0 : cnt_ff + 4'h1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) kind_ff <= 8'h00;
		else if (desc_valid && cnt_ff == 4'h1) kind_ff <= desc_byte;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_wait: assert property (p_wait) else $error("apb answer late");
	property p_start;
		psel && penable && !pready && pwrite && paddr == REG_CTRL && !desc_busy
		&& pwdata[15:8] != 8'h00 && pwdata[7:0] inside {8'h04, 8'h29, 8'h00}
		|-> ##2 desc_valid && desc_byte == 8'h09;
	endproperty
	a_start: assert property (p_start) else $error("stream start wrong");
	property p_second;
		desc_valid && cnt_ff == 4'h1 && $past(desc_byte) == 8'h09
		|-> desc_byte inside {8'h04, 8'h29};
	endproperty
	a_second: assert property (p_second) else $error("type byte wrong");
	property p_ep;
		desc_valid && kind_ff == 8'h05 && cnt_ff >= 4'h2 |-> desc_byte == (cnt_ff == 4'h2 ?
		8'h81 : cnt_ff == 4'h3 ? 8'h03 : cnt_ff == 4'h4 ? 8'h01 : cnt_ff == 4'h5 ? 8'h00 : 8'hff);
	endproperty
	a_ep: assert property (p_ep) else $error("endpoint byte wrong");
	property p_if;
		desc_valid && kind_ff == 8'h04 && cnt_ff >= 4'h2
		|-> desc_byte == (cnt_ff == 4'h4 ? 8'h01 : cnt_ff == 4'h5 ? 8'h09 : 8'h00);
	endproperty
	a_if: assert property (p_if) else $error("interface byte wrong");
	property p_chr;
		desc_valid && kind_ff == 8'h29 && cnt_ff == 4'h3 |-> desc_byte[7:5] == 3'h0
		&& !desc_byte[1] ##1 (!desc_valid || desc_byte == 8'h00);
	endproperty
	a_chr: assert property (p_chr) else $error("characteristics wrong");
	property p_end;
		desc_valid && desc_last |=> !desc_valid && !desc_busy;
	endproperty
	a_end: assert property (p_end) else $error("stream overran");
	property p_len;
		desc_valid |-> desc_busy && cnt_ff < 4'h9;
	endproperty
	a_len: assert property (p_len) else $error("stream too long");
	cover property (desc_valid && desc_last && kind_ff == 8'h05);
	cover property (desc_valid && desc_last && cnt_ff == 4'h8);
	cover property (desc_valid && desc_last && cnt_ff == 4'h0);
endmodule
`default_nettype wire

// ==== verif/hdb_host.sv ====
// host model: makes the apb requests that fetch descriptors
`timescale 1ns/1ps
`default_nettype none
module hdb_host (
	// clock
	input wire logic pclk,
	// apb master
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [11:0] paddr = 12'h0,
	output logic [31:0] pwdata = 32'h0,
	output logic [3:0] pstrb = 4'h0,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// one request at a time, only when the bench asks
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// stale data must not look valid
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the hub descriptor builder
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
	import hdb_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, desc_valid, desc_last, desc_busy, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [31:0] cfg0 = CFG0_RST;
	logic [31:0] cfg1 = CFG1_RST;
	logic [3:0] pstrb;
	logic [7:0] desc_byte;
	logic [8:0] exp_q[$];
	logic [8:0] x;
	logic [7:0] tt[4] = '{8'h04, 8'h05, 8'h29, 8'h00};
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	always #25 pclk = ~pclk;
	hdb_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .desc_byte(desc_byte), .desc_valid(desc_valid),
		.desc_last(desc_last), .desc_busy(desc_busy));
	hdb_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	function automatic logic [7:0] hub_b(int i);
		logic [2:0] m;
		m = cfg0[0] ? cfg0[14:12] : cfg0[10:8];
		case (i)
		0: return 8'h09;
		1: return 8'h29;
		2: return 8'(3 - m[0] - m[1] - m[2]);
		3: return {3'h0, cfg0[4:3], cfg0[2], 1'b0, cfg0[1]};
		4: return 8'h00;
		5: return cfg0[23:16];
		6: return cfg0[0] ? cfg1[15:8] : cfg1[7:0];
		7: return cfg0[31:24];
		default: return 8'hff;
		endcase
	endfunction
	task automatic req(input logic [7:0] t, input logic [7:0] len);
		logic [7:0] ifd[9] = '{8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00};
		logic [7:0] epd[9] = '{8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'hff, 8'h00, 8'h00};
		int d;
		int n;
		logic [7:0] b;
		d = (t == 8'h05) ? 7 : 9;
		n = (t inside {8'h04, 8'h05, 8'h29, 8'h00}) ? ((len < d) ? len : d) : 0;
		b = 8'h00;
		for (int i = 0; i < n; i++) begin
			b = t == 8'h04 ? ifd[i] : t == 8'h05 ? epd[i] : hub_b(i);
			exp_q.push_back({i == n - 1, b});
		end
		host_u.xfer(1'b1, REG_CTRL, {16'h0, len, t}, rd, er);
		repeat (4) @(posedge pclk);
		while (desc_busy === 1'b1) @(posedge pclk);
		`CHK("left", 32'h0, 32'(exp_q.size()))
		host_u.xfer(1'b0, REG_STATUS, 32'h0, rd, er);
		`CHK("error", 1'(n == 0), rd[3])
		host_u.xfer(1'b0, REG_CTRL, 32'h0, rd, er);
		`CHK("ctrl", {16'h0, len, t}, rd)
		if (n > 0) begin
			host_u.xfer(1'b0, REG_DATA, 32'h0, rd, er);
			`CHK("data", {24'h0, b}, rd)
		end
	endtask
	// every byte is compared with the oldest note
	always @(posedge pclk) begin
		if (desc_valid === 1'b1) begin
			x = exp_q.size() ? exp_q.pop_front() : 9'bx;
			`CHK("byte", x, {desc_last, desc_byte})
		end
	end
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 8000) begin
			err_count++;
			test_done;
		end
	end
	initial begin
		void'($urandom(8572));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		host_u.xfer(1'b0, REG_CFG0, 32'h0, rd, er);
		`CHK("cfg0", CFG0_RST, rd)
		host_u.xfer(1'b0, REG_CFG1, 32'h0, rd, er);
		`CHK("cfg1", CFG1_RST, rd)
		host_u.xfer(1'b0, 12'h0f0, 32'h0, rd, er);
		`CHK("unmapped", 1'b1, er)
		$display("test reset done");
		for (int i = 0; i < 4; i++) req(tt[i], 8'h40);
		req(8'h07, 8'h09);
		req(8'h29, 8'h00);
		$display("test fixed done");
		// random configuration, both power sources, truncated lengths
		repeat (12) begin
			cfg0 = $urandom;
			cfg1 = $urandom;
			host_u.xfer(1'b1, REG_CFG0, cfg0, rd, er);
			host_u.xfer(1'b1, REG_CFG1, cfg1, rd, er);
			req(cfg0[5] ? 8'h29 : 8'h00, 8'($urandom % 12 + 1));
			req(tt[$urandom % 4], 8'($urandom % 10 + 1));
		end
		$display("test random done");
		// reset in mid-run: configuration falls back to its defaults
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		cfg0 = CFG0_RST;
		cfg1 = CFG1_RST;
		host_u.xfer(1'b0, REG_CFG0, 32'h0, rd, er);
		`CHK("cfg0 again", CFG0_RST, rd)
		req(8'h29, 8'h09);
		$display("test reset again done");
		test_done;
	end
endmodule
bind hdb_top hdb_chk #(.ADDR_W(ADDR_W)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.desc_byte(desc_byte), .desc_valid(desc_valid), .desc_last(desc_last),
	.desc_busy(desc_busy));
`default_nettype wire
